// *** rtl/cdd_pkg.sv ***
// Constants, register map and state types of the clock divider chain
// Summary of operation
// - Zero-delay bit routes channel 0 to feedback
// - Four channel dividers, ratios 1 through 32
// - Prescaler divides by 1 to 6
// - High N+1, low M+1 input cycles
// - Source bit picks prescaler or direct input
// - Bypass gives divide by one, passthrough
// - Correction on by default, per-channel off bit
// - Uncorrected duty is (N+1)/(N+M+2)
// - Prescaler has a static, non-toggling setting
// - Total ratio is prescaler times channel ratio
// - Coarse delay up to 15 cycles, start level
// - Odd prescaler, bypassed channel: 33.3/40 percent, divide by one stays static
// - Corrected odd prescaler duty rounds high time up: 66.7/60 percent
package cdd_pkg;

  localparam logic [8:0] ZERO_DELAY_OFS = 9'h01e;
  localparam int ZERO_DELAY_BIT = 1;
  localparam logic [8:0] PRESCALE_OFS = 9'h1e0;
  localparam logic [8:0] SOURCE_OFS = 9'h1e1;
  localparam int SOURCE_BIT = 0;
  localparam logic [8:0] STATUS_OFS = 9'h1f0;
  localparam logic [8:0] RESTART_OFS = 9'h1f1;
  localparam int RESTART_BIT = 0;

  localparam logic [8:0] CH_COUNTS_OFS [4] = '{9'h190, 9'h193, 9'h196,
                                               9'h199};
  localparam logic [8:0] CH_CTRL_OFS [4] = '{9'h191, 9'h194, 9'h197,
                                             9'h19a};
  localparam logic [8:0] CH_DCC_OFS [4] = '{9'h192, 9'h195, 9'h198,
                                            9'h19b};

  // Control register fields
  localparam int CTRL_BYPASS_BIT = 7;
  localparam int CTRL_IGNORE_BIT = 6;
  localparam int CTRL_START_HIGH_BIT = 4;
  localparam logic [7:0] CTRL_MASK = 8'hdf;
  localparam int DCC_OFF_BIT = 0;

  // Prescaler select: 0..5 give divide by 1..6, above is static
  localparam logic [2:0] PRE_MAX_SEL = 3'h5;
  localparam logic [2:0] PRE_DIV1_SEL = 3'h0;

  localparam logic [7:0] COUNTS_RST = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic DCC_OFF_RST = 1'b0;
  localparam logic ZERO_DELAY_RST = 1'b0;
  localparam logic [2:0] PRE_SEL_RST = 3'h0;
  localparam logic SOURCE_RST = 1'b0;

  localparam logic [7:0] AGE_MAX = 8'hff;

  typedef struct packed {
    logic [8:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } cdd_bus_req_t;

  typedef struct packed {
    logic [3:0][7:0] counts;
    logic [3:0][7:0] ctrl;
    logic [3:0] dcc_off;
    logic zero_delay;
    logic [2:0] pre_sel;
    logic src_direct;
    logic [3:0][7:0] cnt;
    logic [3:0][7:0] dly;
    logic [3:0] out;
    logic [3:0] follow;
    logic fb_s1;
    logic fb_s2;
    logic fb_s3;
    logic fb_level;
    logic fb_out;
    logic [7:0] rdata;
    logic [7:0] cfg_age;
    logic [7:0] hi_run;
    logic [7:0] lo_run;
  } cdd_state_t;

endpackage

// *** rtl/cdd_top.sv ***
// Prescaler and four channel dividers with register port
`timescale 1ns/100ps
`default_nettype none
module cdd_top (
  input wire logic clk,
  input wire logic reset,
  input wire cdd_pkg::cdd_bus_req_t bus_req,
  output logic [7:0] read_data,
  input wire logic feedback_ref,
  output logic feedback_clk,
  output logic [3:0] channel_out,
  output logic [3:0] channel_follow
);
  import cdd_pkg::*;

  cdd_state_t st;
  cdd_state_t next_st;
  logic [7:0] src_ratio;
  logic [7:0] ratio;
  logic [7:0] period;
  logic [7:0] high_len;
  logic [7:0] delay_len;
  logic [7:0] n_val;
  logic [7:0] m_val;
  logic [7:0] po_val;
  logic pre_static;
  logic hold_static;
  logic restart;
  logic byp;
  logic start_high;

  always_comb begin
    next_st = st;
    next_st.rdata = 8'h00;
    src_ratio = 8'h00;
    ratio = 8'h00;
    period = 8'h00;
    high_len = 8'h00;
    delay_len = 8'h00;
    n_val = 8'h00;
    m_val = 8'h00;
    po_val = 8'h00;
    hold_static = 1'b0;
    byp = 1'b0;
    start_high = 1'b0;
    pre_static = st.pre_sel > PRE_MAX_SEL;
    // Channel input cycle length in clocks
    src_ratio = st.src_direct ? 8'h01 :
                {5'h00, st.pre_sel} + 8'h01;
    restart = bus_req.wr && (bus_req.addr == RESTART_OFS) &&
              bus_req.wdata[RESTART_BIT];

    if (bus_req.wr) begin
      case (bus_req.addr)
        ZERO_DELAY_OFS: next_st.zero_delay = bus_req.wdata[ZERO_DELAY_BIT];
        PRESCALE_OFS: next_st.pre_sel = bus_req.wdata[2:0];
        SOURCE_OFS: next_st.src_direct = bus_req.wdata[SOURCE_BIT];
        default: begin
        end
      endcase
      for (int i = 0; i < 4; i++) begin
        if (bus_req.addr == CH_COUNTS_OFS[i]) begin
          next_st.counts[i] = bus_req.wdata;
        end
        if (bus_req.addr == CH_CTRL_OFS[i]) begin
          next_st.ctrl[i] = bus_req.wdata & CTRL_MASK;
        end
        if (bus_req.addr == CH_DCC_OFS[i]) begin
          next_st.dcc_off[i] = bus_req.wdata[DCC_OFF_BIT];
        end
      end
    end

    if (bus_req.rd) begin
      case (bus_req.addr)
        ZERO_DELAY_OFS: next_st.rdata = {6'h00, st.zero_delay, 1'b0};
        PRESCALE_OFS: next_st.rdata = {5'h00, st.pre_sel};
        SOURCE_OFS: next_st.rdata = {7'h00, st.src_direct};
        STATUS_OFS: next_st.rdata = {st.follow, st.out};
        default: begin
        end
      endcase
      for (int i = 0; i < 4; i++) begin
        if (bus_req.addr == CH_COUNTS_OFS[i]) begin
          next_st.rdata = st.counts[i];
        end
        if (bus_req.addr == CH_CTRL_OFS[i]) begin
          next_st.rdata = st.ctrl[i];
        end
        if (bus_req.addr == CH_DCC_OFS[i]) begin
          next_st.rdata = {7'h00, st.dcc_off[i]};
        end
      end
    end

    for (int i = 0; i < 4; i++) begin
      n_val = {4'h0, st.counts[i][3:0]};
      m_val = {4'h0, st.counts[i][7:4]};
      po_val = {4'h0, st.ctrl[i][3:0]};
      byp = st.ctrl[i][CTRL_BYPASS_BIT];
      start_high = st.ctrl[i][CTRL_START_HIGH_BIT];
      ratio = byp ? 8'h01 : n_val + m_val + 8'h02;
      period = src_ratio * ratio;
      if (st.dcc_off[i]) begin
        // Bypassed channel keeps the prescaler's own shape
        high_len = byp ? (src_ratio >> 1) :
                   src_ratio * (n_val + 8'h01);
      end else begin
        high_len = (period + 8'h01) >> 1;
      end
      if (start_high) begin
        delay_len = src_ratio * (po_val + m_val + 8'h01);
      end else begin
        delay_len = src_ratio * po_val;
      end
      // Divide by one through a bypassed channel stays static
      hold_static = !st.src_direct && (pre_static ||
                    (st.pre_sel == PRE_DIV1_SEL && byp));
      next_st.follow[i] = st.src_direct && byp;
      if (restart && !st.ctrl[i][CTRL_IGNORE_BIT]) begin
        next_st.dly[i] = delay_len;
        next_st.cnt[i] = 8'h00;
        next_st.out[i] = start_high;
      end else if (hold_static || next_st.follow[i]) begin
        next_st.dly[i] = 8'h00;
        next_st.cnt[i] = 8'h00;
        next_st.out[i] = 1'b0;
      end else if (st.dly[i] != 8'h00) begin
        next_st.dly[i] = st.dly[i] - 8'h01;
        next_st.out[i] = start_high;
      end else begin
        next_st.out[i] = st.cnt[i] < high_len;
        if (st.cnt[i] >= period - 8'h01) begin
          next_st.cnt[i] = 8'h00;
        end else begin
          next_st.cnt[i] = st.cnt[i] + 8'h01;
        end
      end
    end

    next_st.fb_s1 = feedback_ref;
    next_st.fb_s2 = st.fb_s1;
    next_st.fb_s3 = st.fb_s2;
    if (st.fb_s2 == st.fb_s3) begin
      next_st.fb_level = st.fb_s3;
    end
    next_st.fb_out = st.zero_delay ? next_st.out[0] : st.fb_level;

    next_st.cfg_age = bus_req.wr ? 8'h00 :
                      (st.cfg_age == AGE_MAX ? AGE_MAX : st.cfg_age + 8'h01);
    next_st.hi_run = st.out[0] ? (st.hi_run == AGE_MAX ? AGE_MAX :
                     st.hi_run + 8'h01) : 8'h00;
    next_st.lo_run = !st.out[0] ? (st.lo_run == AGE_MAX ? AGE_MAX :
                     st.lo_run + 8'h01) : 8'h00;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st <= '0;
      st.counts <= {4{COUNTS_RST}};
      st.ctrl <= {4{CTRL_RST}};
      st.dcc_off <= {4{DCC_OFF_RST}};
      st.zero_delay <= ZERO_DELAY_RST;
      st.pre_sel <= PRE_SEL_RST;
      st.src_direct <= SOURCE_RST;
    end else begin
      st <= next_st;
    end
  end

  assign read_data = st.rdata;
  assign feedback_clk = st.fb_out;
  assign channel_out = st.out;
  assign channel_follow = st.follow;

  // Expected figures for channel 0, from its configuration
  logic [7:0] exp_src;
  logic [7:0] exp_n;
  logic [7:0] exp_m;
  logic ch0_plain;
  assign exp_src = st.src_direct ? 8'h01 : {5'h00, st.pre_sel} + 8'h01;
  assign exp_n = {4'h0, st.counts[0][3:0]};
  assign exp_m = {4'h0, st.counts[0][7:4]};
  assign ch0_plain = (st.cfg_age == AGE_MAX) && !st.ctrl[0][CTRL_BYPASS_BIT]
                     && st.dly[0] == 8'h00 && st.pre_sel <= PRE_MAX_SEL;

  zero_delay_route_a: assert property (@(posedge clk)
    disable iff (reset)
    $past(st.zero_delay) |-> feedback_clk == channel_out[0])
    else $error("feedback not taken from channel 0");

  high_time_a: assert property (@(posedge clk) disable iff (reset)
    (ch0_plain && st.dcc_off[0] && $fell(channel_out[0])) |->
    st.hi_run == exp_src * (exp_n + 8'h01))
    else $error("channel 0 high time wrong");

  low_time_a: assert property (@(posedge clk) disable iff (reset)
    (ch0_plain && st.dcc_off[0] && $rose(channel_out[0])) |->
    st.lo_run == exp_src * (exp_m + 8'h01))
    else $error("channel 0 low time wrong");

  dcc_odd_a: assert property (@(posedge clk) disable iff (reset)
    (ch0_plain && !st.dcc_off[0] && st.src_direct &&
     exp_m == exp_n + 8'h01 && $fell(channel_out[0])) |->
    st.hi_run == exp_n + 8'h02)
    else $error("corrected odd high time wrong");

  pre_shape_a: assert property (@(posedge clk) disable iff (reset)
    ((st.cfg_age == AGE_MAX) && st.ctrl[0][CTRL_BYPASS_BIT] &&
     !st.src_direct && st.dcc_off[0] && st.pre_sel == 3'h2 &&
     st.dly[0] == 8'h00 && $fell(channel_out[0])) |->
    st.hi_run == 8'h01 ##1 !channel_out[0] ##1 channel_out[0])
    else $error("divide by three shape wrong");

  static_out_a: assert property (@(posedge clk) disable iff (reset)
    (st.cfg_age > 8'h01 && !st.src_direct && st.pre_sel > PRE_MAX_SEL) |->
    channel_out == 4'h0)
    else $error("static prescaler outputs toggle");

  bypass_follow_a: assert property (@(posedge clk)
    disable iff (reset)
    (st.cfg_age > 8'h01 && st.src_direct && st.ctrl[0][CTRL_BYPASS_BIT])
    |-> channel_follow[0] && !channel_out[0])
    else $error("bypassed channel not passing input");

  coarse_delay_a: assert property (@(posedge clk)
    disable iff (reset)
    (bus_req.wr && bus_req.addr == RESTART_OFS && bus_req.wdata[0] &&
     st.src_direct && st.ctrl[0] == 8'h03) |=>
    !channel_out[0] [*4] ##1 channel_out[0])
    else $error("coarse delay of three wrong");

  dcc_default_a: assert property (@(posedge clk) disable iff (reset)
    $fell(reset) |-> st.dcc_off == 4'h0)
    else $error("correction not on after reset");

  status_read_a: assert property (@(posedge clk) disable iff (reset)
    (bus_req.rd && bus_req.addr == STATUS_OFS) |=>
    read_data == {$past(channel_follow), $past(channel_out)})
    else $error("status read wrong");

  fb_source_a: assert property (@(posedge clk)
    disable iff (reset)
    !$past(st.zero_delay) |-> feedback_clk == $past(st.fb_level))
    else $error("feedback not taken from synced reference");

  start_level_a: assert property (@(posedge clk)
    disable iff (reset)
    (bus_req.wr && bus_req.addr == RESTART_OFS &&
     bus_req.wdata[RESTART_BIT] && !st.ctrl[0][CTRL_IGNORE_BIT]) |=>
    channel_out[0] == $past(st.ctrl[0][CTRL_START_HIGH_BIT]))
    else $error("restart level of channel 0 wrong");

  follow_map_a: assert property (@(posedge clk)
    disable iff (reset)
    st.cfg_age > 8'h01 |-> channel_follow == ({4{st.src_direct}} &
    {st.ctrl[3][CTRL_BYPASS_BIT], st.ctrl[2][CTRL_BYPASS_BIT],
     st.ctrl[1][CTRL_BYPASS_BIT], st.ctrl[0][CTRL_BYPASS_BIT]}))
    else $error("follow flags do not match bypass");

  zero_delay_c: cover property (@(posedge clk) disable iff (reset)
    st.zero_delay && $rose(feedback_clk));
  follow_c: cover property (@(posedge clk) disable iff (reset)
    $rose(channel_follow[0]));
  delay_run_c: cover property (@(posedge clk) disable iff (reset)
    st.dly[0] == 8'h01 && !st.ctrl[0][CTRL_START_HIGH_BIT]);
  dcc_odd_c: cover property (@(posedge clk) disable iff (reset)
    ch0_plain && !st.dcc_off[0] && $fell(channel_out[0]));
  static_c: cover property (@(posedge clk) disable iff (reset)
    !st.src_direct && st.pre_sel > PRE_MAX_SEL && st.cfg_age > 8'h01);

endmodule
`default_nettype wire

// *** verification/clock_divider_distribution_bench.sv ***
// Self-checking random bench for the clock divider chain
`timescale 1ns/100ps
`default_nettype none
module clock_divider_distribution_bench;
  import cdd_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  cdd_bus_req_t bus_req;
  logic [7:0] read_data;
  logic feedback_ref;
  logic feedback_clk;
  logic [3:0] channel_out;
  logic [3:0] channel_follow;
  int bad_count = 0;
  int n_checks = 0;
  int seed = 32'h38a755ad;

  always #20 clk = ~clk;

  cdd_top DUT (.clk(clk), .reset(reset), .bus_req(bus_req),
    .read_data(read_data), .feedback_ref(feedback_ref),
    .feedback_clk(feedback_clk), .channel_out(channel_out),
    .channel_follow(channel_follow));

  task complete_run;
    $display("Checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task wr_reg(input logic [8:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    bus_req <= '{a, d, 1'b0, 1'b0};
  endtask

  task rd_reg(input logic [8:0] a, output logic [7:0] d);
    @(posedge clk);
    bus_req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk);
    bus_req <= '{a, 8'h00, 1'b0, 1'b0};
    #1 d = read_data;
  endtask

  function automatic logic [7:0] mask_of(input logic [8:0] a);
    logic [7:0] m;
    m = 8'h00;
    for (int i = 0; i < 4; i++) begin
      if (a == CH_COUNTS_OFS[i]) m = 8'hff;
      if (a == CH_CTRL_OFS[i]) m = CTRL_MASK;
      if (a == CH_DCC_OFS[i]) m = 8'h01;
    end
    if (a == ZERO_DELAY_OFS) m = 8'h02;
    if (a == PRESCALE_OFS) m = 8'h07;
    if (a == SOURCE_OFS) m = 8'h01;
    return m;
  endfunction

  task reg_test(input logic [8:0] a);
    logic [7:0] d;
    logic [7:0] r;
    rd_reg(a, r);
    chk("reset value", 8'h00, r);
    d = $random(seed);
    if (mask_of(a) == CTRL_MASK) d[7] = 1'b0;
    wr_reg(a, d);
    rd_reg(a, r);
    chk("read back", d & mask_of(a), r);
    wr_reg(a, 8'h00);
  endtask

  task run_len(input int ch, input logic lvl, output int n);
    n = 0;
    while (channel_out[ch] === lvl && n < 600) begin
      n++;
      @(posedge clk);
      #1;
    end
    if (n >= 600) begin
      bad_count++;
      $display("Error channel %0d expected edge seen none", ch);
      complete_run();
    end
  endtask

  task measure(input int ch, output int hi, output int lo);
    int n;
    @(posedge clk);
    #1;
    run_len(ch, 1'b1, n);
    run_len(ch, 1'b0, n);
    run_len(ch, 1'b1, hi);
    run_len(ch, 1'b0, lo);
  endtask

  initial begin
    repeat (100000) @(posedge clk);
    bad_count++;
    $display("Error run time expected end seen hang");
    complete_run();
  end

  initial begin
    int hi, lo, n, m, s, d0, d1, p, bad;
    logic [7:0] r;
    bus_req = '0;
    feedback_ref = 1'b0;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      reg_test(CH_COUNTS_OFS[i]);
      reg_test(CH_CTRL_OFS[i]);
      reg_test(CH_DCC_OFS[i]);
    end
    reg_test(ZERO_DELAY_OFS);
    reg_test(PRESCALE_OFS);
    reg_test(SOURCE_OFS);
    reg_test(9'h100);
    $display("end registers");
    wr_reg(SOURCE_OFS, 8'h01);
    for (int ch = 0; ch < 4; ch++) begin
      n = $unsigned($random(seed)) % 16;
      m = $unsigned($random(seed)) % 16;
      if (ch == 0) n = n % 15;
      if (ch == 0) m = n + 1;
      if (ch == 2) {n, m} = 0;
      if (ch == 3) {n, m} = {32'd15, 32'd15};
      wr_reg(CH_COUNTS_OFS[ch], {m[3:0], n[3:0]});
      wr_reg(CH_DCC_OFS[ch], 8'h01);
      // Let the checkers in the design see a settled channel 0
      if (ch == 0) repeat (260) @(posedge clk);
      measure(ch, hi, lo);
      chk("high run", n + 1, hi);
      chk("low run", m + 1, lo);
      if (ch == 0) begin
        wr_reg(CH_DCC_OFS[0], 8'h00);
        repeat (260) @(posedge clk);
        measure(0, hi, lo);
        chk("direct corrected high", n + 2, hi);
      end
    end
    $display("end direct ratios");
    wr_reg(SOURCE_OFS, 8'h00);
    for (s = 2; s <= 6; s++) begin
      wr_reg(PRESCALE_OFS, s - 1);
      n = $unsigned($random(seed)) % 8;
      m = n + 1;
      wr_reg(CH_COUNTS_OFS[s % 4], {m[3:0], n[3:0]});
      wr_reg(CH_DCC_OFS[s % 4], 8'h01);
      measure(s % 4, hi, lo);
      chk("scaled high", s * (n + 1), hi);
      chk("scaled low", s * (m + 1), lo);
      wr_reg(CH_DCC_OFS[s % 4], 8'h00);
      measure(s % 4, hi, lo);
      chk("corrected high", (s * (n + m + 2) + 1) / 2, hi);
      chk("period", s * (n + m + 2), hi + lo);
    end
    $display("end prescaled ratios");
    wr_reg(CH_CTRL_OFS[0], 8'h80);
    for (s = 3; s <= 5; s += 2) begin
      wr_reg(PRESCALE_OFS, s - 1);
      wr_reg(CH_DCC_OFS[0], 8'h01);
      repeat (260) @(posedge clk);
      measure(0, hi, lo);
      chk("odd bypass high", s / 2, hi);
      chk("odd bypass low", s - s / 2, lo);
      wr_reg(CH_DCC_OFS[0], 8'h00);
      measure(0, hi, lo);
      chk("odd corrected high", (s + 1) / 2, hi);
    end
    wr_reg(SOURCE_OFS, 8'h01);
    rd_reg(STATUS_OFS, r);
    chk("follow", 2'b10, {channel_follow[0], channel_out[0]});
    chk("status follow", 1'b1, r[4]);
    wr_reg(CH_CTRL_OFS[0], 8'h00);
    wr_reg(SOURCE_OFS, 8'h00);
    wr_reg(PRESCALE_OFS, 8'h06);
    repeat (4) @(posedge clk);
    bad = 0;
    repeat (60) begin
      @(posedge clk);
      #1 if (channel_out !== 4'h0) bad++;
    end
    chk("static outputs", 0, bad);
    $display("end bypass and static");
    wr_reg(SOURCE_OFS, 8'h01);
    wr_reg(CH_COUNTS_OFS[0], 8'hff);
    p = 1 + $unsigned($random(seed)) % 15;
    for (int k = 0; k < 3; k++) begin
      wr_reg(CH_CTRL_OFS[0], (k == 2) ? 8'h03 : k * p);
      wr_reg(RESTART_OFS, 8'h01);
      @(posedge clk);
      #1;
      run_len(0, 1'b0, d1);
      if (k == 0) d0 = d1;
      if (k == 1) chk("phase delay", p, d1 - d0);
    end
    chk("phase three", 3, d1 - d0);
    $display("end phase offset");
    feedback_ref <= 1'b1;
    repeat (8) @(posedge clk);
    #1 chk("feedback ref", 1'b1, feedback_clk);
    wr_reg(ZERO_DELAY_OFS, 8'h02);
    bad = 0;
    repeat (80) begin
      @(posedge clk);
      feedback_ref <= $random(seed);
      #1 if (feedback_clk !== channel_out[0]) bad++;
    end
    chk("zero delay feedback", 0, bad);
    $display("end zero delay");
    complete_run();
  end
endmodule
`default_nettype wire
